// ===== common/lpm_pkg.sv
// Package for the low-power mode and module gating controller.
// Assumes one 100 MHz clock and a synchronous, active-high reset.
package lpm_pkg;
	// Clock
	localparam int CLK_PERIOD_NS = 10;

	// Register offsets (byte addresses on the plain register port)
	localparam logic [7:0] OFS_POWER_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_OSC_CONTROL    = 8'h04;
	localparam logic [7:0] OFS_GATE_CONTROL   = 8'h08;
	localparam logic [7:0] OFS_MODE_STATUS    = 8'h0C;
	localparam logic [7:0] OFS_GATE_REG1      = 8'h10;
	localparam logic [7:0] OFS_GATE_STRIDE    = 8'h04;
	localparam int         GATE_REGS          = 7;

	// Field positions
	localparam int POS_LOW_POWER_REG_SEL  = 1;  // power_control_reg
	localparam int POS_DEEP_HALT_SELECT   = 4;  // oscillator_control_reg
	localparam int POS_GATE_WRITE_GUARD   = 11; // module_gate_control_reg
	localparam int POS_RETENTION_REG_CFG  = 2;  // power_on_config_word, active low

	// Reset values
	localparam logic       RST_LOW_POWER_REG_SEL = 1'b0;
	localparam logic       RST_DEEP_HALT_SELECT  = 1'b0;
	localparam logic       RST_GATE_WRITE_GUARD  = 1'b0;
	localparam logic [31:0] RST_GATE_REG         = 32'h0000_0000;

	// Implemented gate bits per register; all others read zero
	localparam logic [GATE_REGS-1:0][31:0] GATE_IMPL_MASK = {
		32'h0000_0010,  // reg7: dma
		32'h0000_0101,  // reg6: calendar clock, ref clock output
		32'h0107_0707,  // reg5: uart 1-3, spi 1-3, i2c 1-3, usb
		32'h0000_0007,  // reg4: timer 1-3
		32'h0001_FF00,  // reg3: capture/compare 1-9
		32'h0F00_0007,  // reg2: comparators 1-3, logic cells 1-4
		32'h0010_1001   // reg1: converter, voltage reference, voltage detect
	};

	// Gated peripherals that keep clocks in retention sleep
	localparam logic [GATE_REGS-1:0][31:0] RETAIN_KEEP_MASK = {
		32'h0000_0000, 32'h0000_0101, 32'h0000_0000, 32'h0000_0001,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000
	};

	// Gated peripherals that keep clocks in ordinary sleep
	localparam logic [GATE_REGS-1:0][31:0] SLEEP_KEEP_MASK = {
		32'h0000_0000, 32'h0000_0101, 32'h0000_0001, 32'h0000_0001,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0001
	};

	// Pin output rate limit in retention: half period of a 33 kHz output
	localparam int PIN_MIN_HALF_PERIOD_NS = 15152;
	localparam int PIN_MIN_HALF_CYCLES    = (PIN_MIN_HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Operating modes
	typedef enum logic [1:0] {LPM_RUN, LPM_IDLE, LPM_SLEEP, LPM_RETAIN} lpm_mode_t;
endpackage

// ===== common/lpm_if.sv
// Interface joining the power controller to the CPU and peripherals.
// Assumes both ends run on the same core_clk.
`timescale 1ns/1ps
interface lpm_if;
	import lpm_pkg::*;
	logic [7:0]                 sw_addr;
	logic [31:0]                sw_wdata;
	logic                       sw_we;
	logic                       sw_re;
	logic [31:0]                sw_rdata;
	logic                       unlock_active;
	logic [31:0]                config_word;
	logic                       wait_req;
	logic [2:0]                 cpu_prio;
	logic                       irq_valid;
	logic [2:0]                 irq_prio;
	logic                       wdt_timeout;
	logic                       master_clear_pin;
	logic [GATE_REGS-1:0][31:0] halt_in_idle;
	logic                       cpu_halt;
	logic                       por_req;
	lpm_mode_t                  mode;
	logic [GATE_REGS-1:0][31:0] clk_en;
	logic [GATE_REGS-1:0][31:0] reg_wr_en;

	modport dev (
		input  sw_addr, sw_wdata, sw_we, sw_re, unlock_active, config_word, wait_req, cpu_prio,
		       irq_valid, irq_prio, wdt_timeout, master_clear_pin, halt_in_idle,
		output sw_rdata, cpu_halt, por_req, mode, clk_en, reg_wr_en
	);
	modport cpu (
		output sw_addr, sw_wdata, sw_we, sw_re, unlock_active, config_word, wait_req, cpu_prio,
		       irq_valid, irq_prio, wdt_timeout, master_clear_pin, halt_in_idle,
		input  sw_rdata, cpu_halt, por_req, mode, clk_en, reg_wr_en
	);
endinterface

// ===== hdl/lpm_power_ctrl.sv
// Power mode controller and per-peripheral clock gating with write guard.
// Assumes registers are reached through lpm_if; the unlock sequence is
// resolved outside and arrives as a level.
`timescale 1ns/1ps
module lpm_power_ctrl
	import lpm_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// Link to CPU and peripherals
	lpm_if.dev        link
);
	// Register state
	logic                       lp_sel_q, lp_sel_d;
	logic                       deep_halt_q, deep_halt_d;
	logic                       guard_q, guard_d;
	logic [GATE_REGS-1:0][31:0] gate_q, gate_d;
	logic [31:0]                rdata_q, rdata_d;

	// Mode state
	lpm_mode_t                  mode_q, mode_d;
	logic                       halt_q, halt_d;
	logic                       por_q, por_d;
	logic [GATE_REGS-1:0][31:0] clk_en_q, clk_en_d;
	logic [GATE_REGS-1:0][31:0] wr_en_q, wr_en_d;

	// Decoded wake sources
	logic wake_irq;
	logic wake_low_irq;
	logic retain_ok;

	assign wake_irq     = link.irq_valid && (link.irq_prio > link.cpu_prio);
	assign wake_low_irq = link.irq_valid && !(link.irq_prio > link.cpu_prio);
	assign retain_ok    = !link.config_word[POS_RETENTION_REG_CFG] && lp_sel_q;

	// Register writes and read data; reads answer one cycle later
	always_comb begin
		int idx;
		idx         = 0;
		lp_sel_d    = lp_sel_q;
		deep_halt_d = deep_halt_q;
		guard_d     = guard_q;
		gate_d      = gate_q;
		rdata_d     = 32'h0000_0000;
		if (link.sw_we) begin
			case (link.sw_addr)
				OFS_POWER_CONTROL: begin
					lp_sel_d = link.sw_wdata[POS_LOW_POWER_REG_SEL];
				end
				OFS_OSC_CONTROL: begin
					if (link.unlock_active) begin
						deep_halt_d = link.sw_wdata[POS_DEEP_HALT_SELECT];
					end
				end
				OFS_GATE_CONTROL: begin
					// Guarded writes fall through silently
					if (link.unlock_active) begin
						guard_d = link.sw_wdata[POS_GATE_WRITE_GUARD];
					end
				end
				default: begin
					for (int r = 0; r < GATE_REGS; r++) begin
						if (link.sw_addr == OFS_GATE_REG1 + 8'(r) * OFS_GATE_STRIDE && !guard_q) begin
							gate_d[r] = link.sw_wdata & GATE_IMPL_MASK[r];
						end
					end
				end
			endcase
		end
		if (link.sw_re) begin
			case (link.sw_addr)
				OFS_POWER_CONTROL: rdata_d[POS_LOW_POWER_REG_SEL] = lp_sel_q;
				OFS_OSC_CONTROL:   rdata_d[POS_DEEP_HALT_SELECT]  = deep_halt_q;
				OFS_GATE_CONTROL:  rdata_d[POS_GATE_WRITE_GUARD]  = guard_q;
				OFS_MODE_STATUS:   rdata_d = {30'h0000_0000, mode_q};
				default: begin
					// Unmapped addresses read zero
					for (int r = 0; r < GATE_REGS; r++) begin
						if (link.sw_addr == OFS_GATE_REG1 + 8'(r) * OFS_GATE_STRIDE) begin
							idx     = r;
							rdata_d = gate_q[idx];
						end
					end
				end
			endcase
		end
	end

	// Register storage
	always_ff @(posedge core_clk) begin
		if (reset) begin
			lp_sel_q    <= RST_LOW_POWER_REG_SEL;
			deep_halt_q <= RST_DEEP_HALT_SELECT;
			guard_q     <= RST_GATE_WRITE_GUARD;
			gate_q      <= {GATE_REGS{RST_GATE_REG}};
			rdata_q     <= 32'h0000_0000;
		end else begin
			lp_sel_q    <= lp_sel_d;
			deep_halt_q <= deep_halt_d;
			guard_q     <= guard_d;
			gate_q      <= gate_d;
			rdata_q     <= rdata_d;
		end
	end

	// Mode sequencing on halt and wake events
	always_comb begin
		mode_d = mode_q;
		por_d  = 1'b0;
		case (mode_q)
			LPM_RUN: begin
				if (link.wait_req) begin
					if (!deep_halt_q) begin
						mode_d = LPM_IDLE;
					end else if (retain_ok) begin
						mode_d = LPM_RETAIN;
					end else begin
						mode_d = LPM_SLEEP;
					end
				end
			end
			LPM_IDLE: begin
				// Low-priority interrupts leave the CPU halted
				if (wake_irq || link.wdt_timeout) begin
					mode_d = LPM_RUN;
				end
			end
			LPM_SLEEP: begin
				if (wake_irq || link.wdt_timeout) begin
					mode_d = LPM_RUN;
				end else if (wake_low_irq) begin
					mode_d = LPM_IDLE;
				end
			end
			LPM_RETAIN: begin
				if (link.master_clear_pin) begin
					mode_d = LPM_RUN;
					por_d  = 1'b1;
				end else if (wake_irq || link.wdt_timeout) begin
					mode_d = LPM_RUN;
				end
			end
			default: begin
				mode_d = LPM_RUN;
			end
		endcase
		halt_d = (mode_d != LPM_RUN);
	end

	// Clock and register-access enables per gated peripheral
	always_comb begin
		for (int r = 0; r < GATE_REGS; r++) begin
			wr_en_d[r] = GATE_IMPL_MASK[r] & ~gate_d[r];
			case (mode_d)
				LPM_RUN:    clk_en_d[r] = wr_en_d[r];
				LPM_IDLE:   clk_en_d[r] = wr_en_d[r] & ~link.halt_in_idle[r];
				LPM_SLEEP:  clk_en_d[r] = wr_en_d[r] & SLEEP_KEEP_MASK[r];
				LPM_RETAIN: clk_en_d[r] = wr_en_d[r] & RETAIN_KEEP_MASK[r];
				default:    clk_en_d[r] = 32'h0000_0000;
			endcase
		end
	end

	// Mode registers; reset itself ends every low-power mode
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_q   <= LPM_RUN;
			halt_q   <= 1'b0;
			por_q    <= 1'b0;
			clk_en_q <= {GATE_REGS{32'h0000_0000}};
			wr_en_q  <= {GATE_REGS{32'h0000_0000}};
		end else begin
			mode_q   <= mode_d;
			halt_q   <= halt_d;
			por_q    <= por_d;
			clk_en_q <= clk_en_d;
			wr_en_q  <= wr_en_d;
		end
	end

	// Outputs straight from flops
	assign link.sw_rdata  = rdata_q;
	assign link.cpu_halt  = halt_q;
	assign link.por_req   = por_q;
	assign link.mode      = mode_q;
	assign link.clk_en    = clk_en_q;
	assign link.reg_wr_en = wr_en_q;
endmodule

// ===== hdl/lpm_cpu_end.sv
// CPU and peripheral end: forwards software and event requests, and
// rate-limits a pin output while the device sits in retention.
// Assumes the controller end shares core_clk and reset.
`timescale 1ns/1ps
module lpm_cpu_end
	import lpm_pkg::*;
#(
	parameter int HALF_CYCLES = PIN_MIN_HALF_CYCLES
)
(
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       reset,
	// Software register port
	input  wire logic [7:0]                 sw_addr,
	input  wire logic [31:0]                sw_wdata,
	input  wire logic                       sw_we,
	input  wire logic                       sw_re,
	output logic      [31:0]                sw_rdata,
	// Core events
	input  wire logic                       unlock_active,
	input  wire logic [31:0]                config_word,
	input  wire logic                       wait_req,
	input  wire logic [2:0]                 cpu_prio,
	input  wire logic                       irq_valid,
	input  wire logic [2:0]                 irq_prio,
	input  wire logic                       wdt_timeout,
	input  wire logic                       master_clear_pin,
	input  wire logic [GATE_REGS-1:0][31:0] halt_in_idle,
	// Pin output request and result
	input  wire logic                       pin_toggle_req,
	output logic                            pin_out,
	// Status from the controller
	output logic                            cpu_halt,
	output logic                            por_req,
	output logic      [GATE_REGS-1:0][31:0] clk_en,
	// Link to the controller
	lpm_if.cpu                              link
);
	if (HALF_CYCLES < 1 || HALF_CYCLES > 65535) begin : g_chk
		$error("HALF_CYCLES out of range");
	end

	// Request registers
	logic [7:0]                 addr_q;
	logic [31:0]                wdata_q, rdata_q;
	logic                       we_q, re_q, unlock_q, wait_q, irqv_q, wdt_q, master_clear_pin_q;
	logic [2:0]                 cprio_q, iprio_q;
	logic [31:0]                cfg_q;
	logic [GATE_REGS-1:0][31:0] hidl_q;
	logic                       halt_q, por_q;
	logic [GATE_REGS-1:0][31:0] clk_en_q;

	// Pin limiter state
	logic        pin_q, pin_d;
	logic [15:0] gap_q, gap_d;

	// Retention keeps pin edges at least a half period apart
	always_comb begin
		pin_d = pin_q;
		gap_d = (gap_q != 16'h0000) ? gap_q - 16'h0001 : gap_q;
		if (pin_toggle_req && (link.mode != LPM_RETAIN || gap_q == 16'h0000)) begin
			pin_d = !pin_q;
			gap_d = 16'(HALF_CYCLES - 1);
		end
	end

	// Registered forwarding in both directions
	always_ff @(posedge core_clk) begin
		if (reset) begin
			addr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			rdata_q <= 32'h0000_0000;
			{we_q, re_q, unlock_q, wait_q, irqv_q, wdt_q, master_clear_pin_q} <= 7'h00;
			cprio_q <= 3'h0;
			iprio_q <= 3'h0;
			cfg_q <= 32'hFFFF_FFFF;
			hidl_q <= {GATE_REGS{32'h0000_0000}};
			halt_q <= 1'b0;
			por_q <= 1'b0;
			clk_en_q <= {GATE_REGS{32'h0000_0000}};
			pin_q <= 1'b0;
			gap_q <= 16'h0000;
		end else begin
			addr_q <= sw_addr;
			wdata_q <= sw_wdata;
			we_q <= sw_we;
			re_q <= sw_re;
			rdata_q <= link.sw_rdata;
			unlock_q <= unlock_active;
			cfg_q <= config_word;
			wait_q <= wait_req;
			cprio_q <= cpu_prio;
			irqv_q <= irq_valid;
			iprio_q <= irq_prio;
			wdt_q <= wdt_timeout;
			master_clear_pin_q <= master_clear_pin;
			hidl_q <= halt_in_idle;
			halt_q <= link.cpu_halt;
			por_q <= link.por_req;
			clk_en_q <= link.clk_en;
			pin_q <= pin_d;
			gap_q <= gap_d;
		end
	end

	// Drive the link and user outputs from flops
	assign link.sw_addr       = addr_q;
	assign link.sw_wdata      = wdata_q;
	assign link.sw_we         = we_q;
	assign link.sw_re         = re_q;
	assign link.unlock_active = unlock_q;
	assign link.config_word   = cfg_q;
	assign link.wait_req      = wait_q;
	assign link.cpu_prio      = cprio_q;
	assign link.irq_valid     = irqv_q;
	assign link.irq_prio      = iprio_q;
	assign link.wdt_timeout   = wdt_q;
	assign link.master_clear_pin          = master_clear_pin_q;
	assign link.halt_in_idle  = hidl_q;
	assign sw_rdata           = rdata_q;
	assign cpu_halt           = halt_q;
	assign por_req            = por_q;
	assign clk_en             = clk_en_q;
	assign pin_out            = pin_q;
endmodule

// ===== tb/lpm_link_chk.sv
// Checker on the link between controller and cpu end.
// Assumes link signals wired in by name, one clock domain.
`timescale 1ns/1ps
module lpm_link_chk
	import lpm_pkg::*;
(
	// Clock and reset
	input wire logic                       core_clk,
	input wire logic                       reset,
	// Requests and events
	input wire logic                       wait_req,
	input wire logic [31:0]                config_word,
	input wire logic [2:0]                 cpu_prio,
	input wire logic                       irq_valid,
	input wire logic [2:0]                 irq_prio,
	input wire logic                       wdt_timeout,
	input wire logic                       master_clear_pin,
	input wire logic [GATE_REGS-1:0][31:0] halt_in_idle,
	// Controller results
	input wire logic                       cpu_halt,
	input wire logic                       por_req,
	input wire lpm_mode_t                  mode,
	input wire logic [GATE_REGS-1:0][31:0] clk_en,
	input wire logic [GATE_REGS-1:0][31:0] reg_wr_en
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// Wake request that outranks the running code
	wire logic hi_irq = irq_valid && (irq_prio > cpu_prio);

	// Mode transitions
	halt_enter_a: assert property (mode == LPM_RUN && wait_req |=> cpu_halt && mode != LPM_RUN)
		else $error("halt not entered");
	no_retain_a: assert property (mode == LPM_RUN && wait_req && config_word[POS_RETENTION_REG_CFG] |=> mode != LPM_RETAIN)
		else $error("retention without config");
	halt_level_a: assert property (cpu_halt == (mode != LPM_RUN))
		else $error("halt flag disagrees with mode");
	irq_wake_a: assert property (mode == LPM_IDLE && hi_irq |=> mode == LPM_RUN)
		else $error("idle kept past urgent irq");
	idle_hold_a: assert property (mode == LPM_IDLE && !hi_irq && !wdt_timeout |=> mode == LPM_IDLE)
		else $error("idle left without cause");
	wdt_wake_a: assert property (mode == LPM_IDLE && wdt_timeout |=> mode == LPM_RUN)
		else $error("watchdog did not end idle");
	master_clear_pin_por_a: assert property (mode == LPM_RETAIN && master_clear_pin |=> por_req && mode == LPM_RUN ##1 !por_req)
		else $error("master clear wake wrong");

	// Clock enables per mode
	idle_clock_a: assert property (mode == LPM_IDLE && $stable(halt_in_idle) && $stable(reg_wr_en)
		|-> clk_en == (reg_wr_en & ~halt_in_idle))
		else $error("idle clock enables wrong");
	run_clock_a: assert property (mode == LPM_RUN && $past(mode) == LPM_RUN |-> clk_en == reg_wr_en)
		else $error("run clock enables wrong");
	retain_keep_a: assert property (mode == LPM_RETAIN |-> (clk_en & ~RETAIN_KEEP_MASK) == '0)
		else $error("retention clock leak");
endmodule

// ===== tb/tb_low_power_mode_and_module_gating.sv
// Bench for both ends of the power controller link.
// Assumes package, interface and both design ends compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	n_compared++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("FAIL %s exp %h got %h", nm, e, g); \
	end
module tb_low_power_mode_and_module_gating
	import lpm_pkg::*;
;
	logic                       core_clk = 1'b0;
	logic                       reset = 1'b1;
	logic [7:0]                 sw_addr = 8'h00;
	logic [31:0]                sw_wdata = 32'h0, sw_rdata, config_word = '1;
	logic                       sw_we = 1'b0, sw_re = 1'b0, unlock_active = 1'b0, wait_req = 1'b0;
	logic [2:0]                 cpu_prio = 3'h2, irq_prio = 3'h0;
	logic                       irq_valid = 1'b0, wdt_timeout = 1'b0, master_clear_pin = 1'b0, pin_toggle_req = 1'b0;
	logic [GATE_REGS-1:0][31:0] halt_in_idle = '0, clk_en;
	logic                       pin_out, cpu_halt, por_req;
	logic [31:0]                d;
	int                         fails = 0, n_compared = 0;

	// Clock and the two ends
	always #5 core_clk = ~core_clk;
	lpm_if lk();
	lpm_power_ctrl i_lpm_power_ctrl (.core_clk, .reset, .link(lk.dev));
	lpm_cpu_end #(.HALF_CYCLES(4)) i_lpm_cpu_end (.core_clk, .reset, .sw_addr, .sw_wdata, .sw_we, .sw_re,
		.sw_rdata, .unlock_active, .config_word, .wait_req, .cpu_prio, .irq_valid, .irq_prio, .wdt_timeout,
		.master_clear_pin, .halt_in_idle, .pin_toggle_req, .pin_out, .cpu_halt, .por_req, .clk_en, .link(lk.cpu));
	lpm_link_chk i_lpm_link_chk (.core_clk, .reset, .wait_req(lk.wait_req), .config_word(lk.config_word),
		.cpu_prio(lk.cpu_prio), .irq_valid(lk.irq_valid), .irq_prio(lk.irq_prio), .wdt_timeout(lk.wdt_timeout),
		.master_clear_pin(lk.master_clear_pin), .halt_in_idle(lk.halt_in_idle), .cpu_halt(lk.cpu_halt), .por_req(lk.por_req),
		.mode(lk.mode), .clk_en(lk.clk_en), .reg_wr_en(lk.reg_wr_en));

	task final_report;
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Bus cycles; read data taken at the user port, one flop behind the link
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_we <= 1'b1;
		@(posedge core_clk);
		sw_we <= 1'b0;
	endtask
	task wr_unl(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		unlock_active <= 1'b1;
		wr(a, v);
		@(posedge core_clk);
		unlock_active <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge core_clk);
		sw_addr <= a;
		sw_re <= 1'b1;
		@(posedge core_clk);
		sw_re <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 d = sw_rdata;
	endtask
	task halt;
		@(posedge core_clk);
		wait_req <= 1'b1;
		@(posedge core_clk);
		wait_req <= 1'b0;
	endtask
	// Bounded wait; caller judges the mode
	task wait_mode(input lpm_mode_t m);
		for (int i = 0; i < 8 && lk.mode !== m; i++) begin
			@(posedge core_clk);
			#1;
		end
	endtask

	task t_reset_vals;
		for (int i = 0; i < GATE_REGS; i++) begin
			rd(OFS_GATE_REG1 + 8'(i * 4));
			`CHK("gate reset", 32'h0, d)
		end
		`CHK("clk_en reset", GATE_IMPL_MASK, lk.clk_en)
	endtask

	// All ones into every gate register, then cleared again
	task t_layout;
		for (int i = 0; i < GATE_REGS; i++) begin
			wr(OFS_GATE_REG1 + 8'(i * 4), 32'hFFFF_FFFF);
			rd(OFS_GATE_REG1 + 8'(i * 4));
			`CHK("gate bits", GATE_IMPL_MASK[i], d)
			`CHK("gated clk", 32'h0, lk.clk_en[i])
			`CHK("gated wr", 32'h0, lk.reg_wr_en[i])
			wr(OFS_GATE_REG1 + 8'(i * 4), 32'h0);
		end
	endtask

	task t_guard;
		wr(OFS_GATE_CONTROL, 32'h0000_0800);
		wr(OFS_GATE_REG1, 32'h1);
		rd(OFS_GATE_REG1);
		`CHK("guard locked", 32'h1, d)
		wr_unl(OFS_GATE_CONTROL, 32'h0000_0800);
		wr(OFS_GATE_REG1, 32'h0);
		rd(OFS_GATE_REG1);
		`CHK("guarded write", 32'h1, d)
		rd(OFS_GATE_CONTROL);
		`CHK("guard set", 32'h0000_0800, d)
		// Clearing the guard without unlock must not take
		wr(OFS_GATE_CONTROL, 32'h0);
		rd(OFS_GATE_CONTROL);
		`CHK("guard kept", 32'h0000_0800, d)
		wr_unl(OFS_GATE_CONTROL, 32'h0);
		wr(OFS_GATE_REG1, 32'h0);
		rd(OFS_GATE_REG1);
		`CHK("unguarded write", 32'h0, d)
	endtask

	// Idle entry, low then high interrupt, watchdog wake
	task t_idle;
		@(posedge core_clk);
		halt_in_idle[3][0] <= 1'b1;
		halt;
		wait_mode(LPM_IDLE);
		`CHK("idle mode", LPM_IDLE, lk.mode)
		`CHK("idle halt", 1'b1, lk.cpu_halt)
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("idle stop", 1'b0, lk.clk_en[3][0])
		`CHK("idle run", 1'b1, lk.clk_en[4][0])
		`CHK("user halt", 1'b1, cpu_halt)
		`CHK("user stop", 1'b0, clk_en[3][0])
		@(posedge core_clk);
		irq_prio <= 3'h2;
		irq_valid <= 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		`CHK("low irq", LPM_IDLE, lk.mode)
		@(posedge core_clk);
		irq_prio <= 3'h5;
		wait_mode(LPM_RUN);
		`CHK("high irq", LPM_RUN, lk.mode)
		@(posedge core_clk);
		irq_valid <= 1'b0;
		halt_in_idle <= '0;
		halt;
		wait_mode(LPM_IDLE);
		@(posedge core_clk);
		wdt_timeout <= 1'b1;
		@(posedge core_clk);
		wdt_timeout <= 1'b0;
		wait_mode(LPM_RUN);
		`CHK("wdt wake", LPM_RUN, lk.mode)
	endtask

	task t_sleep;
		wr(OFS_OSC_CONTROL, 32'h10);
		rd(OFS_OSC_CONTROL);
		`CHK("deep locked", 32'h0, d)
		halt;
		wait_mode(LPM_IDLE);
		`CHK("locked deep", LPM_IDLE, lk.mode)
		@(posedge core_clk);
		irq_valid <= 1'b1;
		wait_mode(LPM_RUN);
		@(posedge core_clk);
		irq_valid <= 1'b0;
		wr_unl(OFS_OSC_CONTROL, 32'h10);
		rd(OFS_OSC_CONTROL);
		`CHK("deep set", 32'h0000_0010, d)
		halt;
		wait_mode(LPM_SLEEP);
		`CHK("sleep mode", LPM_SLEEP, lk.mode)
		`CHK("sleep clk", GATE_IMPL_MASK & SLEEP_KEEP_MASK, lk.clk_en)
		rd(OFS_MODE_STATUS);
		`CHK("sleep status", 32'(LPM_SLEEP), d)
		// Low-priority interrupt only moves sleep to idle
		@(posedge core_clk);
		irq_prio <= 3'h2;
		irq_valid <= 1'b1;
		wait_mode(LPM_IDLE);
		`CHK("sleep low irq", LPM_IDLE, lk.mode)
		@(posedge core_clk);
		irq_prio <= 3'h5;
		wait_mode(LPM_RUN);
		`CHK("sleep wake", LPM_RUN, lk.mode)
		@(posedge core_clk);
		irq_valid <= 1'b0;
	endtask

	// Retention entry, pin rate, master clear wake
	task t_retain;
		logic last;
		int   gap, n, bad;
		config_word <= 32'hFFFF_FFFB;
		wr(OFS_POWER_CONTROL, 32'h2);
		halt;
		wait_mode(LPM_RETAIN);
		`CHK("retain mode", LPM_RETAIN, lk.mode)
		`CHK("retain clk", GATE_IMPL_MASK & RETAIN_KEEP_MASK, lk.clk_en)
		last = pin_out;
		gap = 4;
		n = 0;
		bad = 0;
		@(posedge core_clk);
		pin_toggle_req <= 1'b1;
		repeat (20) begin
			@(posedge core_clk);
			#1 gap++;
			if (pin_out !== last) begin
				bad = bad | (gap < 4);
				n++;
				gap = 0;
				last = pin_out;
			end
		end
		@(posedge core_clk);
		pin_toggle_req <= 1'b0;
		`CHK("pin rate", 1'b1, n > 0 && bad == 0)
		master_clear_pin <= 1'b1;
		@(posedge core_clk);
		master_clear_pin <= 1'b0;
		for (int i = 0; i < 8 && lk.por_req !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		`CHK("por pulse", 1'b1, lk.por_req)
		`CHK("por run", LPM_RUN, lk.mode)
		// Pulse lasts one cycle, user copy one flop later
		@(posedge core_clk);
		#1;
		`CHK("por single", 1'b0, lk.por_req)
		`CHK("user por", 1'b1, por_req)
		@(posedge core_clk);
		config_word <= '1;
		halt;
		wait_mode(LPM_SLEEP);
		`CHK("no retain", LPM_SLEEP, lk.mode)
		@(posedge core_clk);
		irq_valid <= 1'b1;
		wait_mode(LPM_RUN);
		@(posedge core_clk);
		irq_valid <= 1'b0;
	endtask

	task t_reset_wake;
		wr_unl(OFS_OSC_CONTROL, 32'h0);
		halt;
		wait_mode(LPM_IDLE);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		`CHK("reset wake", LPM_RUN, lk.mode)
		`CHK("reset unhalt", 1'b0, lk.cpu_halt)
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
		t_reset_vals;
		t_layout;
		t_guard;
		t_idle;
		t_sleep;
		t_retain;
		t_reset_wake;
		final_report;
	end

	// Watchdog against a hang
	initial begin
		#50000;
		fails++;
		final_report;
	end
endmodule
